// file: cfs_status_regs.sv
// read-only charger temperature and protection status registers
`timescale 1ns/1ps

// How it works
// [RULE1] bit 4 at 0x1f is one while battery is too low for boost output
// [RULE2] bit 3 at 0x1f is one while temperature is in the cold zone
// [RULE3] bit 2 at 0x1f is one while temperature is in the cool zone
// [RULE4] bit 1 at 0x1f is one while temperature is in the warm zone
// [RULE5] bit 0 at 0x1f is one while temperature is in the hot zone
// [RULE6] bit 7 at 0x20 is one while battery discharge current is regulated
// [RULE7] bits 6, 1, 0 at 0x20 show bus, second and first adapter over-voltage
// [RULE8] bit 5 at 0x20 is one while battery over-voltage protection is active
// [RULE9] bit 4 at 0x20 is one while input over-current protection is active
// [RULE10] bit 3 at 0x20 is one while battery over-current protection is active
// [RULE11] bit 2 at 0x20 is one while the converter is in over-current protection
// [RULE12] bit 7 at 0x21 is one while system rail short protection is active
// [RULE13] bit 6 at 0x21 is one while system rail over-voltage protection is active
// [RULE14] bit 5 at 0x21 is one while the boost output is over-voltage
// [RULE15] bit 4 at 0x21 is one while the boost output is under-voltage
// [RULE16] bit 2 at 0x21 is one during thermal shutdown; bits 3, 1, 0 reserved
// [RULE17] all bits read-only, zero after reset, reserved bits always zero
// [RULE18] bits follow live condition levels, writes never change read values
module cfs_status_regs
  import cfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [CFS_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [CFS_DATA_W-1:0] reg_wdata,
  output logic [CFS_DATA_W-1:0] reg_rdata,
  output logic reg_ack,
  output logic reg_hit,
  input wire logic battery_too_low_for_boost,
  input wire logic temp_zone_cold,
  input wire logic temp_zone_cool,
  input wire logic temp_zone_warm,
  input wire logic temp_zone_hot,
  input wire logic discharge_current_regulating,
  input wire logic bus_input_overvoltage,
  input wire logic battery_overvoltage,
  input wire logic input_overcurrent,
  input wire logic battery_overcurrent,
  input wire logic converter_overcurrent,
  input wire logic second_adapter_overvoltage,
  input wire logic first_adapter_overvoltage,
  input wire logic system_rail_short,
  input wire logic system_rail_overvoltage,
  input wire logic boost_output_overvoltage,
  input wire logic boost_output_undervoltage,
  input wire logic thermal_shutdown_active
);

  logic [7:0] temp_otg_q;
  logic [7:0] temp_otg_d;
  logic [7:0] prot_first_q;
  logic [7:0] prot_first_d;
  logic [7:0] prot_second_q;
  logic [7:0] prot_second_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic ack_q;
  logic ack_d;
  logic hit_q;
  logic hit_d;
  logic addr_ok;

  // live condition capture; writes have no path into these
  always_comb begin
    temp_otg_d = CFS_RST_TEMP_OTG;
    temp_otg_d[CFS_B_BOOST_LOW] = battery_too_low_for_boost; // [RULE1] [RULE18]
    temp_otg_d[CFS_B_COLD] = temp_zone_cold; // [RULE2]
    temp_otg_d[CFS_B_COOL] = temp_zone_cool; // [RULE3]
    temp_otg_d[CFS_B_WARM] = temp_zone_warm; // [RULE4]
    temp_otg_d[CFS_B_HOT] = temp_zone_hot; // [RULE5]
    temp_otg_d = temp_otg_d & CFS_MASK_TEMP_OTG; // [RULE17]

    prot_first_d = CFS_RST_PROT_FIRST;
    prot_first_d[CFS_B_DISCHG_REG] = discharge_current_regulating; // [RULE6]
    prot_first_d[CFS_B_BUS_OVP] = bus_input_overvoltage; // [RULE7]
    prot_first_d[CFS_B_ADP2_OVP] = second_adapter_overvoltage; // [RULE7]
    prot_first_d[CFS_B_ADP1_OVP] = first_adapter_overvoltage; // [RULE7]
    prot_first_d[CFS_B_BAT_OVP] = battery_overvoltage; // [RULE8]
    prot_first_d[CFS_B_IN_OCP] = input_overcurrent; // [RULE9]
    prot_first_d[CFS_B_BAT_OCP] = battery_overcurrent; // [RULE10]
    prot_first_d[CFS_B_CONV_OCP] = converter_overcurrent; // [RULE11]
    prot_first_d = prot_first_d & CFS_MASK_PROT_FIRST;

    prot_second_d = CFS_RST_PROT_SECOND;
    prot_second_d[CFS_B_SYS_SHORT] = system_rail_short; // [RULE12]
    prot_second_d[CFS_B_SYS_OVP] = system_rail_overvoltage; // [RULE13]
    prot_second_d[CFS_B_BOOST_OVP] = boost_output_overvoltage; // [RULE14]
    prot_second_d[CFS_B_BOOST_UVP] = boost_output_undervoltage; // [RULE15]
    prot_second_d[CFS_B_TSHUT] = thermal_shutdown_active; // [RULE16]
    prot_second_d = prot_second_d & CFS_MASK_PROT_SECOND; // [RULE16] [RULE17]
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      temp_otg_q <= CFS_RST_TEMP_OTG; // [RULE17]
      prot_first_q <= CFS_RST_PROT_FIRST; // [RULE17]
      prot_second_q <= CFS_RST_PROT_SECOND; // [RULE17]
    end else begin
      temp_otg_q <= temp_otg_d;
      prot_first_q <= prot_first_d;
      prot_second_q <= prot_second_d;
    end
  end

  // register access port; write data is accepted and dropped
  always_comb begin
    addr_ok = 1'b0;
    rdata_d = rdata_q;
    ack_d = reg_rd | reg_wr;
    hit_d = 1'b0;
    case (reg_addr)
      CFS_OFF_TEMP_OTG: begin
        addr_ok = 1'b1;
      end
      CFS_OFF_PROT_FIRST: begin
        addr_ok = 1'b1;
      end
      CFS_OFF_PROT_SECOND: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
    if (reg_rd | reg_wr) begin
      hit_d = addr_ok;
    end
    if (reg_rd) begin
      case (reg_addr)
        CFS_OFF_TEMP_OTG: begin
          rdata_d = temp_otg_q;
        end
        CFS_OFF_PROT_FIRST: begin
          rdata_d = prot_first_q;
        end
        CFS_OFF_PROT_SECOND: begin
          rdata_d = prot_second_q;
        end
        default: begin
          rdata_d = CFS_RDATA_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_q <= CFS_RDATA_UNMAPPED;
      ack_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      hit_q <= hit_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign reg_hit = hit_q;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_read_temp;
    reg_rd && (reg_addr == CFS_OFF_TEMP_OTG);
  endsequence

  sequence s_read_first;
    reg_rd && (reg_addr == CFS_OFF_PROT_FIRST);
  endsequence

  sequence s_read_second;
    reg_rd && (reg_addr == CFS_OFF_PROT_SECOND);
  endsequence

  // condition present one cycle, then read in the next cycle, reaches read data
  AST_BOOST_LOW_READ: assert property ( // [RULE1]
    battery_too_low_for_boost ##1 s_read_temp |=> reg_rdata[CFS_B_BOOST_LOW] && reg_ack)
    else $error("boost low bit not seen on read");

  AST_TEMP_ZONES: assert property ( // [RULE2]
    nrst |=> temp_otg_q[3:0] ==
      $past({temp_zone_cold, temp_zone_cool, temp_zone_warm, temp_zone_hot}))
    else $error("temperature zone bits do not follow inputs");

  AST_COOL_READ: assert property ( // [RULE3]
    !temp_zone_cool ##1 s_read_temp |=> !reg_rdata[CFS_B_COOL])
    else $error("cool bit set while zone inactive");

  AST_WARM_READ: assert property ( // [RULE4]
    temp_zone_warm ##1 s_read_temp |=> reg_rdata[CFS_B_WARM])
    else $error("warm bit missing on read");

  AST_HOT_READ: assert property ( // [RULE5]
    temp_zone_hot ##1 s_read_temp |=> reg_rdata[CFS_B_HOT])
    else $error("hot bit missing on read");

  AST_DISCHG_READ: assert property ( // [RULE6]
    discharge_current_regulating ##1 s_read_first |=> reg_rdata[CFS_B_DISCHG_REG])
    else $error("discharge regulation bit missing");

  AST_OVP_INPUTS: assert property ( // [RULE7]
    nrst |=> {prot_first_q[CFS_B_BUS_OVP], prot_first_q[CFS_B_ADP2_OVP],
      prot_first_q[CFS_B_ADP1_OVP]} == $past({bus_input_overvoltage,
      second_adapter_overvoltage, first_adapter_overvoltage}))
    else $error("input over-voltage bits do not follow inputs");

  AST_BAT_OVP: assert property ( // [RULE8]
    battery_overvoltage ##1 s_read_first |=> reg_rdata[CFS_B_BAT_OVP])
    else $error("battery over-voltage bit missing");

  AST_IN_OCP: assert property ( // [RULE9]
    !input_overcurrent ##1 s_read_first |=> !reg_rdata[CFS_B_IN_OCP])
    else $error("input over-current bit set while inactive");

  AST_BAT_OCP: assert property ( // [RULE10]
    battery_overcurrent ##1 s_read_first |=> reg_rdata[CFS_B_BAT_OCP])
    else $error("battery over-current bit missing");

  AST_CONV_OCP: assert property ( // [RULE11]
    converter_overcurrent[*2] |-> prot_first_q[CFS_B_CONV_OCP])
    else $error("converter over-current bit missing");

  AST_SYS_SHORT: assert property ( // [RULE12]
    system_rail_short ##1 s_read_second |=> reg_rdata[CFS_B_SYS_SHORT])
    else $error("system short bit missing");

  AST_SYS_OVP: assert property ( // [RULE13]
    !system_rail_overvoltage ##1 s_read_second |=> !reg_rdata[CFS_B_SYS_OVP])
    else $error("system over-voltage bit set while inactive");

  AST_BOOST_VOLT: assert property ( // [RULE14]
    nrst |=> {prot_second_q[CFS_B_BOOST_OVP], prot_second_q[CFS_B_BOOST_UVP]} ==
      $past({boost_output_overvoltage, boost_output_undervoltage}))
    else $error("boost output voltage bits do not follow inputs");

  AST_BOOST_UVP: assert property ( // [RULE15]
    boost_output_undervoltage ##1 s_read_second |=> reg_rdata[CFS_B_BOOST_UVP])
    else $error("boost under-voltage bit missing");

  AST_TSHUT_RSVD: assert property ( // [RULE16]
    thermal_shutdown_active ##1 s_read_second |=>
      reg_rdata[CFS_B_TSHUT] && (reg_rdata[3] == 1'b0) && (reg_rdata[1:0] == 2'b00))
    else $error("thermal shutdown or reserved bits wrong");

  AST_RSVD_ZERO: assert property ( // [RULE17]
    s_read_temp |=> reg_rdata[7:5] == 3'b000)
    else $error("reserved bits of temperature register not zero");

  AST_RESET_CLEAR: assert property ( // [RULE17]
    disable iff (1'b0) !nrst |=> (temp_otg_q == CFS_RST_TEMP_OTG) &&
      (prot_first_q == CFS_RST_PROT_FIRST) && (prot_second_q == CFS_RST_PROT_SECOND)
      && !reg_ack)
    else $error("status not cleared by reset");

  AST_WRITE_NO_EFFECT: assert property ( // [RULE18]
    reg_wr && (reg_addr == CFS_OFF_PROT_FIRST) && !first_adapter_overvoltage
      ##1 (!first_adapter_overvoltage and s_read_first) |=> !reg_rdata[CFS_B_ADP1_OVP])
    else $error("write changed a status bit");

  AST_ACK_TIMING: assert property ( // [RULE18]
    (reg_rd || reg_wr) |=> reg_ack ##1 (reg_ack == $past(reg_rd || reg_wr)))
    else $error("acknowledge timing wrong");

  AST_UNMAPPED: assert property ( // [RULE17]
    reg_rd && (reg_addr > CFS_OFF_PROT_SECOND) |=> (reg_rdata == CFS_RDATA_UNMAPPED)
      && !reg_hit)
    else $error("unmapped read not zero");

endmodule

// file: cfs_pkg.sv
// constants for the charger fault status register bank
package cfs_pkg;
  localparam int unsigned CFS_ADDR_W = 8;
  localparam int unsigned CFS_DATA_W = 8;

  // register offsets
  localparam logic [7:0] CFS_OFF_TEMP_OTG = 8'h1f;
  localparam logic [7:0] CFS_OFF_PROT_FIRST = 8'h20;
  localparam logic [7:0] CFS_OFF_PROT_SECOND = 8'h21;

  // values after reset
  localparam logic [7:0] CFS_RST_TEMP_OTG = 8'h00;
  localparam logic [7:0] CFS_RST_PROT_FIRST = 8'h00;
  localparam logic [7:0] CFS_RST_PROT_SECOND = 8'h00;
  localparam logic [7:0] CFS_RDATA_UNMAPPED = 8'h00;

  // field positions, temperature and boost register
  localparam int unsigned CFS_B_BOOST_LOW = 4;
  localparam int unsigned CFS_B_COLD = 3;
  localparam int unsigned CFS_B_COOL = 2;
  localparam int unsigned CFS_B_WARM = 1;
  localparam int unsigned CFS_B_HOT = 0;

  // field positions, first protection register
  localparam int unsigned CFS_B_DISCHG_REG = 7;
  localparam int unsigned CFS_B_BUS_OVP = 6;
  localparam int unsigned CFS_B_BAT_OVP = 5;
  localparam int unsigned CFS_B_IN_OCP = 4;
  localparam int unsigned CFS_B_BAT_OCP = 3;
  localparam int unsigned CFS_B_CONV_OCP = 2;
  localparam int unsigned CFS_B_ADP2_OVP = 1;
  localparam int unsigned CFS_B_ADP1_OVP = 0;

  // field positions, second protection register
  localparam int unsigned CFS_B_SYS_SHORT = 7;
  localparam int unsigned CFS_B_SYS_OVP = 6;
  localparam int unsigned CFS_B_BOOST_OVP = 5;
  localparam int unsigned CFS_B_BOOST_UVP = 4;
  localparam int unsigned CFS_B_TSHUT = 2;

  // masks of implemented bits; all others read zero
  localparam logic [7:0] CFS_MASK_TEMP_OTG = 8'h1f;
  localparam logic [7:0] CFS_MASK_PROT_FIRST = 8'hff;
  localparam logic [7:0] CFS_MASK_PROT_SECOND = 8'hf4;
endpackage

// file: cfs_host_model.sv
// host processor model issuing single register accesses
`timescale 1ns/1ps
module cfs_host_model
  import cfs_pkg::*;
(
  input wire logic ref_clk,
  output logic [CFS_ADDR_W-1:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [CFS_DATA_W-1:0] reg_wdata,
  input wire logic [CFS_DATA_W-1:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_hit
);
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // one request cycle, answer taken one cycle later
  task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] wd,
                        output logic [7:0] rdat, output logic ack, output logic hit);
    @(posedge ref_clk);
    #1;
    reg_rd = rd;
    reg_wr = ~rd;
    reg_addr = addr;
    reg_wdata = wd;
    @(posedge ref_clk);
    #1;
    rdat = reg_rdata;
    ack = reg_ack;
    hit = reg_hit;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    // released bus shows no stale value
    reg_addr = ~addr;
    reg_wdata = ~wd;
  endtask

  // write, then a read of the same register in the very next cycle
  task automatic write_then_read(input logic [7:0] addr, input logic [7:0] wd,
                                 output logic [7:0] rdat, output logic wack,
                                 output logic rack);
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = wd;
    @(posedge ref_clk);
    #1;
    wack = reg_ack;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    rdat = reg_rdata;
    rack = reg_ack;
    reg_rd = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~wd;
  endtask
endmodule

// file: tb_charger_fault_status_regs.sv
// self-checking bench for the charger status register bank
`timescale 1ns/1ps
module tb_charger_fault_status_regs
  import cfs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [17:0] cond = 18'h3ffff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, last_q;
  logic reg_rd, reg_wr, reg_ack, reg_hit;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] wr_rd_data;
  logic wr_ack;
  logic rd_ack;

  always #25 ref_clk = ~ref_clk;

  cfs_host_model cfs_host_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_hit(reg_hit));

  cfs_status_regs cfs_status_regs_i (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_hit(reg_hit), .battery_too_low_for_boost(cond[17]),
    .temp_zone_cold(cond[16]), .temp_zone_cool(cond[15]), .temp_zone_warm(cond[14]),
    .temp_zone_hot(cond[13]), .discharge_current_regulating(cond[12]),
    .bus_input_overvoltage(cond[11]), .battery_overvoltage(cond[10]),
    .input_overcurrent(cond[9]), .battery_overcurrent(cond[8]),
    .converter_overcurrent(cond[7]), .second_adapter_overvoltage(cond[6]),
    .first_adapter_overvoltage(cond[5]), .system_rail_short(cond[4]),
    .system_rail_overvoltage(cond[3]), .boost_output_overvoltage(cond[2]),
    .boost_output_undervoltage(cond[1]), .thermal_shutdown_active(cond[0]));

  // expected register contents for a condition vector
  function automatic logic [7:0] exp_reg(input logic [7:0] a, input logic [17:0] c);
    case (a)
      8'h1f: exp_reg = {3'h0, c[17:13]};
      8'h20: exp_reg = c[12:5];
      8'h21: exp_reg = {c[4:1], 1'b0, c[0], 2'h0};
      default: exp_reg = 8'h00;
    endcase
  endfunction

  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: data %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // one access with all its answers checked
  task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] wd);
    logic [7:0] d;
    logic k;
    logic h;
    cfs_host_model_i.access(rd, a, wd, d, k, h);
    chk1(k, 1'b1);
    chk1(h, a >= 8'h1f && a <= 8'h21);
    chk8(d, rd ? exp_reg(a, cond) : last_q);
    last_q = d;
  endtask

  task automatic set_cond(input logic [17:0] v);
    @(posedge ref_clk);
    #1;
    cond = v;
  endtask

  task automatic read_all();
    acc(1'b1, 8'h1f, 8'h00);
    acc(1'b1, 8'h20, 8'h00);
    acc(1'b1, 8'h21, 8'h00);
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    void'($urandom(62));
    last_q = 8'h00;
    repeat (10) @(posedge ref_clk);
    #1;
    chk8(reg_rdata, 8'h00);
    chk1(reg_ack, 1'b0);
    nrst = 1'b1;
    $display("test reset done");
    read_all();
    for (int i = 0; i < 18; i++) begin
      set_cond(18'h1 << i);
      read_all();
    end
    $display("test single conditions done");
    set_cond(18'h3ffff);
    for (int a = 8'h1e; a <= 8'h22; a++) begin
      acc(1'b0, 8'(a), 8'hff);
      acc(1'b1, 8'(a), 8'h00);
    end
    $display("test writes and unmapped done");
    for (int i = 0; i < 8; i++) begin
      set_cond(18'($urandom) & ~18'h00020);
      cfs_host_model_i.write_then_read(8'h20, 8'($urandom), wr_rd_data, wr_ack, rd_ack);
      chk1(wr_ack, 1'b1);
      chk1(rd_ack, 1'b1);
      chk8(wr_rd_data, exp_reg(8'h20, cond));
      last_q = wr_rd_data;
    end
    $display("test write then read done");
    for (int i = 0; i < 60; i++) begin
      set_cond(18'($urandom));
      acc(1'($urandom), 8'h1e + 8'($urandom_range(4)), 8'($urandom));
    end
    $display("test random done");
    test_done();
  end
endmodule
